// ---- tcoc_defs.svh ----
// Purpose: offsets, field positions and reset values of the capture and output control
// Assumes: 16-bit memory address space, 8-bit data
// Notes: index 0 is the first timer instance, index 1 the second
`ifndef TCOC_DEFS_SVH
`define TCOC_DEFS_SVH

`define TCOC_ADDR_CAPCMP_CONTROL_A 16'hffbc
`define TCOC_ADDR_OUTPUT_CONTROL_A 16'hffbd
`define TCOC_ADDR_CAPCMP_CONTROL_B 16'hffb8
`define TCOC_ADDR_OUTPUT_CONTROL_B 16'hffb9

`define TCOC_CAPCMP_RESET 8'h00
`define TCOC_OUTPUT_RESET 8'h00
`define TCOC_CAPCMP_WMASK 8'h07
`define TCOC_OUTPUT_WMASK 8'h33
`define TCOC_REG_RESET 16'h0000

// capture/compare control fields
`define TCOC_FIRST_REG_MODE_BIT 0
`define TCOC_CAPTURE_TRIGGER_SELECT 1
`define TCOC_SECOND_REG_MODE_BIT 2

// output control fields
`define TCOC_OUTPUT_ENABLE_BIT 0
`define TCOC_INVERT_ON_FIRST_MATCH 1
`define TCOC_FLIPFLOP_RESET_BIT 2
`define TCOC_FLIPFLOP_SET_BIT 3
`define TCOC_INVERT_ON_SECOND_MATCH 4
`define TCOC_ONESHOT_ENABLE 5
`define TCOC_ONESHOT_SW_TRIGGER 6

`endif

// ---- tcoc_pkg.sv ----
// Purpose: types of the capture and output control
// Assumes: counter mode and edge codes come from the counter's own registers
// Notes: none
package tcoc_pkg;

    typedef enum logic [1:0] {
        TCOC_EDGE_FALLING = 2'b00,
        TCOC_EDGE_RISING = 2'b01,
        TCOC_EDGE_BAD = 2'b10,
        TCOC_EDGE_BOTH = 2'b11
    } tcoc_edge_e;

    typedef enum logic [1:0] {
        TCOC_MODE_STOP = 2'b00,
        TCOC_MODE_FREE_RUN = 2'b01,
        TCOC_MODE_EDGE_CLEAR = 2'b10,
        TCOC_MODE_MATCH_CLEAR = 2'b11
    } tcoc_mode_e;

endpackage : tcoc_pkg

// ---- tcoc_timer_capture_output.sv ----
// Purpose: capture/compare and timer output control for two timer instances
// Assumes: inputs synchronous to i_clock; counter, mode and edge selects external
// Notes: bus writes carry a bit mask so bit and byte accesses both work
//
// Functional notes
// - reset clears capture/compare control to zero
// - second register: compare at 0, capture at 1
// - first register: compare at 0, capture at 1
// - first capture trigger: second pin or first opposite
// - no first-pin capture with both edges selected
// - reset clears output control to zero
// - software trigger fires, self-clears, reads zero
// - one-shot enable: successive at 0, one-shot 1
// - second match toggles flip-flop when enabled
// - first match toggles flip-flop when enabled
// - set/reset pair: keep, clear, set, 11 prohibited
// - set and reset bits read zero
// - output forced low unless output enabled
// - one-shot only free-run or edge-clear modes
`timescale 1ns/1ps
`include "tcoc_defs.svh"

module tcoc_timer_capture_output (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] i_wmask,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic [1:0][15:0] i_sixteen_bit_counter,
    input wire logic [1:0] i_count_tick,
    input wire logic [1:0][2:0] i_counter_mode_control,
    input wire logic [1:0][1:0] i_first_edge_select,
    input wire logic [1:0][1:0] i_second_edge_select,
    input wire logic [1:0] i_first_trigger_input,
    input wire logic [1:0] i_second_trigger_input,
    input wire logic [1:0][15:0] i_capcmp_wdata,
    input wire logic [1:0] i_first_capcmp_we,
    input wire logic [1:0] i_second_capcmp_we,
    output logic [1:0][15:0] o_first_capcmp_reg,
    output logic [1:0][15:0] o_second_capcmp_reg,
    output logic [1:0] o_first_match,
    output logic [1:0] o_second_match,
    output logic [1:0] o_oneshot_trigger,
    output logic [1:0] o_timer_output_pin
);

    ////////////////////////////////////////////////////////////////////////////////
    // per instance control
    logic [7:0] rd_part [2];

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_inst
            localparam logic [15:0] CAPCMP_ADDR = (g == 0) ?
                `TCOC_ADDR_CAPCMP_CONTROL_A : `TCOC_ADDR_CAPCMP_CONTROL_B;
            localparam logic [15:0] OUTPUT_ADDR = (g == 0) ?
                `TCOC_ADDR_OUTPUT_CONTROL_A : `TCOC_ADDR_OUTPUT_CONTROL_B;

            logic [7:0] capcmp_control;
            logic [7:0] output_control;
            logic output_flipflop;
            logic pin;
            logic armed;
            logic first_prev;
            logic second_prev;
            logic [15:0] first_capcmp_reg;
            logic [15:0] second_capcmp_reg;
            logic [7:0] wbits;
            logic capcmp_wr;
            logic output_wr;
            logic first_rise;
            logic first_fall;
            logic second_rise;
            logic second_fall;
            logic first_valid;
            logic first_opposite;
            logic second_valid;
            logic first_both;
            logic first_capture;
            logic second_capture;
            logic running;
            logic first_hit;
            logic second_hit;
            logic oneshot_mode_ok;
            logic oneshot_trigger;
            logic first_toggle;
            logic second_toggle;
            logic next_flipflop;
            tcoc_pkg::tcoc_mode_e mode;
            tcoc_pkg::tcoc_edge_e first_sel;
            tcoc_pkg::tcoc_edge_e second_sel;

            ////////////////////////////////////////////////////////////////////////
            // decode and effective written bits
            assign capcmp_wr = i_wr && (i_addr == CAPCMP_ADDR);
            assign output_wr = i_wr && (i_addr == OUTPUT_ADDR);
            assign wbits = i_wdata & i_wmask;

            assign mode = tcoc_pkg::tcoc_mode_e'(i_counter_mode_control[g][2:1]);
            assign first_sel = tcoc_pkg::tcoc_edge_e'(i_first_edge_select[g]);
            assign second_sel = tcoc_pkg::tcoc_edge_e'(i_second_edge_select[g]);
            assign running = (mode != tcoc_pkg::TCOC_MODE_STOP);

            ////////////////////////////////////////////////////////////////////////
            // control registers
            always_ff @(posedge i_clock) begin
                if (!i_nrst) begin
                    capcmp_control <= `TCOC_CAPCMP_RESET;
                end else if (capcmp_wr) begin
                    capcmp_control <= ((capcmp_control & ~i_wmask) | wbits)
                        & `TCOC_CAPCMP_WMASK;
                end
            end

            always_ff @(posedge i_clock) begin
                if (!i_nrst) begin
                    output_control <= `TCOC_OUTPUT_RESET;
                end else if (output_wr) begin
                    // trigger and set/reset bits are never stored
                    output_control <= ((output_control & ~i_wmask) | wbits)
                        & `TCOC_OUTPUT_WMASK;
                end
            end

            ////////////////////////////////////////////////////////////////////////
            // trigger edge detection
            always_ff @(posedge i_clock) begin
                if (!i_nrst) begin
                    first_prev <= 1'b0;
                    second_prev <= 1'b0;
                end else begin
                    first_prev <= i_first_trigger_input[g];
                    second_prev <= i_second_trigger_input[g];
                end
            end

            assign first_rise = i_first_trigger_input[g] && !first_prev;
            assign first_fall = !i_first_trigger_input[g] && first_prev;
            assign second_rise = i_second_trigger_input[g] && !second_prev;
            assign second_fall = !i_second_trigger_input[g] && second_prev;
            assign first_both = (first_sel == tcoc_pkg::TCOC_EDGE_BOTH);

            always_comb begin
                first_valid = 1'b0;
                first_opposite = 1'b0;
                second_valid = 1'b0;
                case (first_sel)
                    tcoc_pkg::TCOC_EDGE_FALLING: begin
                        first_valid = first_fall;
                        first_opposite = first_rise;
                    end
                    tcoc_pkg::TCOC_EDGE_RISING: begin
                        first_valid = first_rise;
                        first_opposite = first_fall;
                    end
                    tcoc_pkg::TCOC_EDGE_BOTH: begin
                        first_valid = first_rise || first_fall;
                        first_opposite = 1'b0;
                    end
                    default: begin
                        first_valid = 1'b0;
                        first_opposite = 1'b0;
                    end
                endcase
                case (second_sel)
                    tcoc_pkg::TCOC_EDGE_FALLING: second_valid = second_fall;
                    tcoc_pkg::TCOC_EDGE_RISING: second_valid = second_rise;
                    tcoc_pkg::TCOC_EDGE_BOTH: second_valid = second_rise || second_fall;
                    default: second_valid = 1'b0;
                endcase
            end

            // capture triggers
            always_comb begin
                if (capcmp_control[`TCOC_CAPTURE_TRIGGER_SELECT]) begin
                    first_capture = first_opposite && !first_both;
                end else begin
                    first_capture = second_valid;
                end
                second_capture = first_valid && !first_both;
            end

            ////////////////////////////////////////////////////////////////////////
            // capture/compare registers
            always_ff @(posedge i_clock) begin
                if (!i_nrst) begin
                    first_capcmp_reg <= `TCOC_REG_RESET;
                end else if (capcmp_control[`TCOC_FIRST_REG_MODE_BIT]) begin
                    if (first_capture) begin
                        first_capcmp_reg <= i_sixteen_bit_counter[g];
                    end
                end else if (i_first_capcmp_we[g]) begin
                    first_capcmp_reg <= i_capcmp_wdata[g];
                end
            end

            always_ff @(posedge i_clock) begin
                if (!i_nrst) begin
                    second_capcmp_reg <= `TCOC_REG_RESET;
                end else if (capcmp_control[`TCOC_SECOND_REG_MODE_BIT]) begin
                    if (second_capture) begin
                        second_capcmp_reg <= i_sixteen_bit_counter[g];
                    end
                end else if (i_second_capcmp_we[g]) begin
                    second_capcmp_reg <= i_capcmp_wdata[g];
                end
            end

            // matches only in compare mode while counting
            assign first_hit = running && i_count_tick[g]
                && !capcmp_control[`TCOC_FIRST_REG_MODE_BIT]
                && (i_sixteen_bit_counter[g] == first_capcmp_reg);
            assign second_hit = running && i_count_tick[g]
                && !capcmp_control[`TCOC_SECOND_REG_MODE_BIT]
                && (i_sixteen_bit_counter[g] == second_capcmp_reg);

            ////////////////////////////////////////////////////////////////////////
            // one-shot control
            assign oneshot_mode_ok = (mode == tcoc_pkg::TCOC_MODE_FREE_RUN)
                || (mode == tcoc_pkg::TCOC_MODE_EDGE_CLEAR);
            assign oneshot_trigger = output_control[`TCOC_ONESHOT_ENABLE] && oneshot_mode_ok
                && ((output_wr && wbits[`TCOC_ONESHOT_SW_TRIGGER])
                || ((mode == tcoc_pkg::TCOC_MODE_EDGE_CLEAR) && first_valid));

            always_ff @(posedge i_clock) begin
                if (!i_nrst) begin
                    armed <= 1'b0;
                end else if (!output_control[`TCOC_ONESHOT_ENABLE] || !oneshot_mode_ok) begin
                    armed <= 1'b0;
                end else if (oneshot_trigger) begin
                    armed <= 1'b1;
                end else if (first_hit) begin
                    armed <= 1'b0;
                end
            end

            ////////////////////////////////////////////////////////////////////////
            // output flip-flop and pin
            always_comb begin
                if (output_control[`TCOC_ONESHOT_ENABLE]) begin
                    first_toggle = first_hit && armed;
                    second_toggle = second_hit && armed;
                end else begin
                    first_toggle = first_hit;
                    second_toggle = second_hit;
                end
                first_toggle = first_toggle
                    && output_control[`TCOC_INVERT_ON_FIRST_MATCH];
                second_toggle = second_toggle
                    && output_control[`TCOC_INVERT_ON_SECOND_MATCH];
                next_flipflop = output_flipflop ^ (first_toggle ^ second_toggle);
                if (output_wr) begin
                    case ({wbits[`TCOC_FLIPFLOP_SET_BIT], wbits[`TCOC_FLIPFLOP_RESET_BIT]})
                        2'b01: next_flipflop = 1'b0;
                        2'b10: next_flipflop = 1'b1;
                        default: next_flipflop = next_flipflop;
                    endcase
                end
            end

            always_ff @(posedge i_clock) begin
                if (!i_nrst) begin
                    output_flipflop <= 1'b0;
                    pin <= 1'b0;
                end else begin
                    output_flipflop <= next_flipflop;
                    pin <= output_control[`TCOC_OUTPUT_ENABLE_BIT] && output_flipflop;
                end
            end

            ////////////////////////////////////////////////////////////////////////
            // outputs and read data
            assign o_first_capcmp_reg[g] = first_capcmp_reg;
            assign o_second_capcmp_reg[g] = second_capcmp_reg;
            assign o_first_match[g] = first_hit;
            assign o_second_match[g] = second_hit;
            assign o_oneshot_trigger[g] = oneshot_trigger;
            assign o_timer_output_pin[g] = pin;

            always_comb begin
                if (i_addr == CAPCMP_ADDR) begin
                    rd_part[g] = capcmp_control;
                end else if (i_addr == OUTPUT_ADDR) begin
                    rd_part[g] = output_control;
                end else begin
                    rd_part[g] = 8'h00;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // registered read port
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= rd_part[0] | rd_part[1];
        end
    end

endmodule : tcoc_timer_capture_output

// ---- tcoc_checker.sv ----
// Purpose: port checks for the capture and output control
// Assumes: one clock, synchronous active-low reset
// Notes: bound to the design after the module
`timescale 1ns/1ps
`include "tcoc_defs.svh"
module tcoc_checker (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic [15:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic [1:0][15:0] i_sixteen_bit_counter,
    input wire logic [1:0] i_count_tick,
    input wire logic [1:0][2:0] i_counter_mode_control,
    input wire logic [1:0] i_first_trigger_input,
    input wire logic [1:0] i_second_trigger_input,
    input wire logic [1:0] i_first_capcmp_we,
    input wire logic [1:0] i_second_capcmp_we,
    input wire logic [1:0][15:0] o_first_capcmp_reg,
    input wire logic [1:0][15:0] o_second_capcmp_reg,
    input wire logic [1:0] o_first_match,
    input wire logic [1:0] o_second_match,
    input wire logic [1:0] o_oneshot_trigger,
    input wire logic [1:0] o_timer_output_pin
);
    default clocking dc @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    ////////////////////////////////////////////////////////////////////////////////
    AST_RESET_CLEARS: assert property (
        $rose(i_nrst) |-> o_rdata == 8'h00 && o_timer_output_pin == 2'b00)
        else $error("outputs not cleared by reset");
    AST_MATCH_NEEDS_RUN: assert property (
        (o_first_match[0] || o_second_match[0]) |->
        i_count_tick[0] && i_counter_mode_control[0][2:1] != 2'b00)
        else $error("match without tick or while stopped");
    AST_FIRST_MATCH_EQ: assert property (
        o_first_match[0] |-> i_sixteen_bit_counter[0] == o_first_capcmp_reg[0])
        else $error("first match with unequal counter");
    AST_SECOND_MATCH_EQ: assert property (
        o_second_match[0] |-> i_sixteen_bit_counter[0] == o_second_capcmp_reg[0])
        else $error("second match with unequal counter");
    AST_NO_STRAY_CAPTURE: assert property (
        $past(i_nrst) && !i_first_capcmp_we[1] && $stable(i_first_trigger_input[1])
        && $stable(i_second_trigger_input[1]) |=> $stable(o_first_capcmp_reg[1]))
        else $error("first register changed without a pin edge");
    AST_CAPTURE_VALUE: assert property (
        $past(i_nrst) && $changed(o_second_capcmp_reg[1]) && !$past(i_second_capcmp_we[1])
        |-> o_second_capcmp_reg[1] == $past(i_sixteen_bit_counter[1]))
        else $error("captured value is not the counter");
    AST_PIN_CAUSE: assert property (
        $past(i_nrst) && $past(i_nrst, 2) && $changed(o_timer_output_pin[0]) |->
        $past(i_wr, 2) || $past(o_first_match[0], 2) || $past(o_second_match[0], 2))
        else $error("output pin moved without write or match");
    AST_OUTCTL_READ: assert property (
        i_rd && (i_addr == `TCOC_ADDR_OUTPUT_CONTROL_A || i_addr == `TCOC_ADDR_OUTPUT_CONTROL_B)
        |=> o_rdata[7:6] == 2'b00 && o_rdata[3:2] == 2'b00)
        else $error("output control read shows write-only bits");
    AST_ONESHOT_MODE: assert property (
        o_oneshot_trigger[0] |-> i_counter_mode_control[0][2:1] inside {2'b01, 2'b10})
        else $error("one-shot trigger in wrong counter mode");
    C_MATCH: cover property (o_first_match[0]);
    C_ONESHOT: cover property (o_oneshot_trigger[0]);
    C_CAPTURE: cover property ($changed(o_second_capcmp_reg[1]));
endmodule : tcoc_checker

bind tcoc_timer_capture_output tcoc_checker i_chk (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_sixteen_bit_counter(i_sixteen_bit_counter),
    .i_count_tick(i_count_tick), .i_counter_mode_control(i_counter_mode_control),
    .i_first_trigger_input(i_first_trigger_input),
    .i_second_trigger_input(i_second_trigger_input),
    .i_first_capcmp_we(i_first_capcmp_we), .i_second_capcmp_we(i_second_capcmp_we),
    .o_first_capcmp_reg(o_first_capcmp_reg), .o_second_capcmp_reg(o_second_capcmp_reg),
    .o_first_match(o_first_match), .o_second_match(o_second_match),
    .o_oneshot_trigger(o_oneshot_trigger), .o_timer_output_pin(o_timer_output_pin)
);

// ---- tcoc_pin_model.sv ----
// Purpose: far-side driver of the capture trigger pins
// Assumes: pins idle low
// Notes: every level is held at least three i_clock cycles
`timescale 1ns/1ps
module tcoc_pin_model (
    input wire logic i_clock,
    output logic [1:0] o_first_trigger_input,
    output logic [1:0] o_second_trigger_input
);
    initial begin
        o_first_trigger_input = 2'b00;
        o_second_trigger_input = 2'b00;
    end
    task set_pin(input int g, input bit second, input logic lv);
        @(negedge i_clock);
        if (second) begin
            o_second_trigger_input[g] = lv;
        end else begin
            o_first_trigger_input[g] = lv;
        end
        repeat (3) @(negedge i_clock);
    endtask : set_pin
endmodule : tcoc_pin_model

// ---- tb_timer_capture_and_output_control.sv ----
// Purpose: self-checking bench of the capture and output control
// Assumes: instance 0 for output logic, instance 1 for capture
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
`include "tcoc_defs.svh"
module tb_timer_capture_and_output_control;
    localparam logic [15:0] ca = `TCOC_ADDR_CAPCMP_CONTROL_A;
    localparam logic [15:0] oa = `TCOC_ADDR_OUTPUT_CONTROL_A;
    localparam logic [15:0] cb = `TCOC_ADDR_CAPCMP_CONTROL_B;
    localparam logic [15:0] ob = `TCOC_ADDR_OUTPUT_CONTROL_B;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic wrs = 1'b0;
    logic rds = 1'b0;
    logic os;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic [7:0] wmask = 8'h00;
    logic [7:0] rdata;
    logic [1:0] hit;
    logic [1:0][15:0] cnt = '0;
    logic [1:0][15:0] cwd = '0;
    logic [1:0][15:0] r1, r2;
    logic [1:0][2:0] mode = '0;
    logic [1:0][1:0] fes = '0;
    logic [1:0][1:0] ses = '0;
    logic [1:0] tick = '0;
    logic [1:0] fwe = '0;
    logic [1:0] swe = '0;
    logic [1:0] fm, sm, ost, pin, ti1, ti2;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    always #25 clk = ~clk;
    tcoc_timer_capture_output i_dut (
        .i_clock(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wmask(wmask),
        .i_wr(wrs), .i_rd(rds), .o_rdata(rdata), .i_sixteen_bit_counter(cnt),
        .i_count_tick(tick), .i_counter_mode_control(mode), .i_first_edge_select(fes),
        .i_second_edge_select(ses), .i_first_trigger_input(ti1),
        .i_second_trigger_input(ti2), .i_capcmp_wdata(cwd), .i_first_capcmp_we(fwe),
        .i_second_capcmp_we(swe), .o_first_capcmp_reg(r1), .o_second_capcmp_reg(r2),
        .o_first_match(fm), .o_second_match(sm), .o_oneshot_trigger(ost),
        .o_timer_output_pin(pin)
    );
    tcoc_pin_model i_pm (.i_clock(clk), .o_first_trigger_input(ti1),
        .o_second_trigger_input(ti2));
    ////////////////////////////////////////////////////////////////////////////////
    task give_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task bw(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
        @(negedge clk);
        addr = a;
        wdata = d;
        wmask = m;
        wrs = 1'b1;
        #1 os = ost[0];
        @(negedge clk);
        wrs = 1'b0;
    endtask : bw
    task rdc(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        rds = 1'b1;
        @(negedge clk);
        rds = 1'b0;
        chk({8'h00, rdata}, {8'h00, e});
    endtask : rdc
    task tk(input logic [15:0] c);
        @(negedge clk);
        cnt[0] = c;
        tick[0] = 1'b1;
        #1 hit = {fm[0], sm[0]};
        @(negedge clk);
        tick[0] = 1'b0;
    endtask : tk
    task pc(input logic e);
        @(negedge clk);
        chk({15'h0000, pin[0]}, {15'h0000, e});
    endtask : pc
    ////////////////////////////////////////////////////////////////////////////////
    task t_regs;
        rdc(ca, 8'h00);
        rdc(oa, 8'h00);
        bw(ca, 8'hff, 8'hff);
        rdc(ca, 8'h07);
        bw(ca, 8'h00, 8'hff);
        bw(ob, 8'hb5, 8'hff);
        rdc(ob, 8'h31);
        bw(ob, 8'h00, 8'hff);
    endtask : t_regs
    task t_flipflop;
        bw(oa, 8'h01, 8'hff);
        pc(1'b0);
        bw(oa, 8'h08, 8'h08);
        pc(1'b1);
        rdc(oa, 8'h01);
        bw(oa, 8'h0c, 8'h0c);
        pc(1'b1);
        bw(oa, 8'h04, 8'h04);
        pc(1'b0);
        bw(oa, 8'h08, 8'h08);
        bw(oa, 8'h00, 8'h01);
        pc(1'b0);
        bw(oa, 8'h01, 8'h01);
        pc(1'b1);
    endtask : t_flipflop
    task t_match;
        cwd[0] = 16'h0005;
        fwe[0] = 1'b1;
        @(negedge clk);
        fwe[0] = 1'b0;
        cwd[0] = 16'h0009;
        swe[0] = 1'b1;
        @(negedge clk);
        swe[0] = 1'b0;
        chk(r1[0], 16'h0005);
        chk(r2[0], 16'h0009);
        bw(oa, 8'h03, 8'hff);
        mode[0] = 3'b010;
        tk(16'h0005);
        chk({14'h0000, hit}, 16'h0002);
        pc(1'b0);
        tk(16'h0004);
        chk({14'h0000, hit}, 16'h0000);
        pc(1'b0);
        tk(16'h0009);
        chk({14'h0000, hit}, 16'h0001);
        pc(1'b0);
        mode[0] = 3'b000;
        bw(oa, 8'h11, 8'hff);
        mode[0] = 3'b010;
        tk(16'h0009);
        pc(1'b1);
        tk(16'h0005);
        pc(1'b1);
    endtask : t_match
    task t_oneshot;
        mode[0] = 3'b000;
        bw(oa, 8'h23, 8'hff);
        mode[0] = 3'b010;
        tk(16'h0005);
        pc(1'b1);
        bw(oa, 8'h40, 8'h40);
        chk({15'h0000, os}, 16'h0001);
        rdc(oa, 8'h23);
        tk(16'h0005);
        pc(1'b0);
        tk(16'h0005);
        pc(1'b0);
        mode[0] = 3'b110;
        bw(oa, 8'h40, 8'h40);
        chk({15'h0000, os}, 16'h0000);
        mode[0] = 3'b100;
        i_pm.set_pin(0, 1'b0, 1'b1);
        i_pm.set_pin(0, 1'b0, 1'b0);
        tk(16'h0005);
        pc(1'b1);
        mode[0] = 3'b000;
    endtask : t_oneshot
    task t_capture;
        bw(cb, 8'h07, 8'hff);
        mode[1] = 3'b010;
        fes[1] = 2'b01;
        cnt[1] = 16'h1234;
        i_pm.set_pin(1, 1'b0, 1'b1);
        cnt[1] = 16'h2345;
        i_pm.set_pin(1, 1'b0, 1'b0);
        chk(r2[1], 16'h1234);
        chk(r1[1], 16'h2345);
        fes[1] = 2'b11;
        cnt[1] = 16'h3456;
        i_pm.set_pin(1, 1'b0, 1'b1);
        i_pm.set_pin(1, 1'b0, 1'b0);
        chk(r1[1], 16'h2345);
        chk(r2[1], 16'h1234);
        mode[1] = 3'b000;
        bw(cb, 8'h00, 8'h02);
        mode[1] = 3'b010;
        cnt[1] = 16'h4567;
        i_pm.set_pin(1, 1'b1, 1'b1);
        i_pm.set_pin(1, 1'b1, 1'b0);
        chk(r1[1], 16'h4567);
    endtask : t_capture
    initial begin
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        t_regs();
        t_flipflop();
        t_match();
        t_oneshot();
        t_capture();
        give_verdict();
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            give_verdict();
        end
    end
endmodule : tb_timer_capture_and_output_control
